// ==== hdl/erf_pkg.sv ====
// package for the receive filter and watermark block: offsets, fields, carriers
package erf_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_FILTER_CONFIG = 8'h00;
   localparam logic [7:0] IDX_WATERMARKS = 8'h01;
   localparam logic [7:0] IDX_CONTROL = 8'h02;
   localparam logic [7:0] IDX_STATUS = 8'h03;
   localparam logic [7:0] IDX_STATION_LO = 8'h04;
   localparam logic [7:0] IDX_STATION_HI = 8'h05;
   localparam logic [7:0] IDX_CHECKSUM = 8'h06;
   localparam logic [9:0] ADDR_FILTER_CONFIG = {IDX_FILTER_CONFIG, 2'b00};
   localparam logic [9:0] ADDR_WATERMARKS = {IDX_WATERMARKS, 2'b00};
   localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
   localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
   localparam logic [9:0] ADDR_STATION_LO = {IDX_STATION_LO, 2'b00};
   localparam logic [9:0] ADDR_STATION_HI = {IDX_STATION_HI, 2'b00};
   localparam logic [9:0] ADDR_CHECKSUM = {IDX_CHECKSUM, 2'b00};

   // filter configuration field positions
   localparam int FC_BCAST = 0;
   localparam int FC_GROUP = 1;
   localparam int FC_FOREIGN = 2;
   localparam int FC_STATION = 3;
   localparam int FC_SHORT_REJ = 4;
   localparam int FC_SHORT_COL = 5;
   localparam int FC_GOOD_CRC = 6;
   localparam int FC_BAD_CRC = 7;
   localparam int FC_SEL_LSB = 8;
   localparam int FC_INVERT = 12;
   localparam int FC_WAKEUP = 14;
   localparam int FC_HASH = 15;
   localparam logic [31:0] FC_WRITE_MASK = 32'h0000_dfff;
   // watermark field positions
   localparam int WM_EMPTY_LSB = 0;
   localparam int WM_FULL_LSB = 16;
   localparam logic [31:0] WM_WRITE_MASK = 32'h00ff_00ff;
   // own control / status bits
   localparam int CT_RX_EN = 0;
   localparam int CT_AUTO_FC = 1;
   localparam int ST_FULL_EVT = 0;
   localparam int ST_EMPTY_EVT = 1;
   localparam int ST_FC_ON = 2;
   localparam int ST_LAST_ACC = 3;
   localparam int ST_LAST_VALID = 4;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [15:0] SHORT_FRAME_BYTES = 16'h0040;
   localparam logic [47:0] BCAST_ADDR = 48'hffff_ffff_ffff;

   typedef enum logic [3:0] {
      PM_OFF = 4'h0, PM_CSUM = 4'h1, PM_STA_A = 4'h2, PM_STA_B = 4'h3,
      PM_UNI_A = 4'h4, PM_UNI_B = 4'h5, PM_BC_A = 4'h6, PM_BC_B = 4'h7,
      PM_HASH = 4'h8, PM_WAKE = 4'h9
   } erf_pm_e;

   // one received frame's descriptor from the MAC receive path
   typedef struct packed {
      logic [47:0] dest_addr;
      logic [15:0] length;
      logic crc_ok;
      logic [15:0] checksum;
      logic hash_hit;
      logic wakeup_hit;
   } erf_frame_s;
endpackage

// ==== hdl/erf_rx_filter.sv ====
// receive frame filter and receive buffer watermark logic
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - selector zero: pattern match always fails.
// - selector 0001: match is invert XOR checksum equal.
// - selector 0010/0011: checksum condition and destination equals station address.
// - selector 0100/0101: checksum condition and destination is unicast.
// - selector 0110/0111: checksum condition and destination is broadcast.
// - selector 1000: checksum condition and hash hit, regardless of hash enable.
// - selector 1001: checksum condition and wake-up hit, regardless of its enable.
// - invert set needs checksum mismatch; clear needs checksum match.
// - bad-crc collect: accept only frames with invalid crc.
// - good-crc only: accept only frames with valid crc.
// - short collect: accept only frames under 64 bytes, with good crc if required.
// - short reject: reject frames under 64 bytes.
// - station unicast enable accepts unicast to our address.
// - foreign unicast enable accepts unicast to other addresses.
// - group enable accepts multicast frames other than broadcast.
// - all-ones enable accepts broadcast frames.
// - count reaching full mark raises full event; auto flow control turns on.
// - count reaching empty mark raises empty event; auto flow control turns off.
// - bit 15 enables hash filter, bit 14 enables wake-up filter.
module erf_rx_filter (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [9:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // frame from receive path
   input wire logic frame_valid,
   input wire erf_pkg::erf_frame_s frame,
   input wire logic [7:0] rx_buffer_count,
   // results
   output logic decision_valid,
   output logic frame_accept,
   output logic full_level_event,
   output logic empty_level_event,
   output logic flow_control_on,
   output logic receiver_enable
);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [31:0] fc_q;
   logic [31:0] wm_q;
   logic [1:0] ctl_q;
   logic [47:0] station_q;
   logic [15:0] csum_q;
   logic [31:0] rdata_q;
   logic dec_valid_q, accept_q, last_acc_q, last_valid_q;
   logic full_evt_q, empty_evt_q, fc_on_q;

   wire sel_fc = reg_addr == erf_pkg::ADDR_FILTER_CONFIG;
   wire sel_wm = reg_addr == erf_pkg::ADDR_WATERMARKS;
   wire sel_ct = reg_addr == erf_pkg::ADDR_CONTROL;
   wire sel_st = reg_addr == erf_pkg::ADDR_STATUS;
   wire sel_lo = reg_addr == erf_pkg::ADDR_STATION_LO;
   wire sel_hi = reg_addr == erf_pkg::ADDR_STATION_HI;
   wire sel_cs = reg_addr == erf_pkg::ADDR_CHECKSUM;

   // config writes are taken only with the receiver off, so a frame never sees a half-changed filter
   wire fc_wr_ok = reg_wr & sel_fc & ~ctl_q[erf_pkg::CT_RX_EN];
   wire st_clr = reg_wr & sel_st;

   wire [31:0] status_word = {27'h0, last_valid_q, last_acc_q, fc_on_q, empty_evt_q, full_evt_q};
   wire [31:0] rd_mux =
      sel_fc ? fc_q :
      sel_wm ? wm_q :
      sel_ct ? {30'h0, ctl_q} :
      sel_st ? status_word :
      sel_lo ? station_q[31:0] :
      sel_hi ? {16'h0, station_q[47:32]} :
      sel_cs ? {16'h0, csum_q} : 32'h0;

   // ------------------------------------------------------------
   // pattern match
   // ------------------------------------------------------------
   wire [3:0] pm_sel = fc_q[erf_pkg::FC_SEL_LSB +: 4];
   wire invert = fc_q[erf_pkg::FC_INVERT];
   wire is_group = frame.dest_addr[40];
   wire is_bcast = frame.dest_addr == erf_pkg::BCAST_ADDR;
   wire is_unicast = ~is_group;
   wire is_station = frame.dest_addr == station_q;
   wire csum_cond = invert ^ (frame.checksum == csum_q);

   logic pm_hit;
   always_comb begin
      case (pm_sel)
         erf_pkg::PM_OFF: pm_hit = 1'b0;
         erf_pkg::PM_CSUM: pm_hit = csum_cond;
         erf_pkg::PM_STA_A, erf_pkg::PM_STA_B: pm_hit = csum_cond & is_station;
         erf_pkg::PM_UNI_A, erf_pkg::PM_UNI_B: pm_hit = csum_cond & is_unicast;
         erf_pkg::PM_BC_A, erf_pkg::PM_BC_B: pm_hit = csum_cond & is_bcast;
         erf_pkg::PM_HASH: pm_hit = csum_cond & frame.hash_hit;
         erf_pkg::PM_WAKE: pm_hit = csum_cond & frame.wakeup_hit;
         default: pm_hit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // mandatory checks and acceptance
   // ------------------------------------------------------------
   wire is_short = frame.length < erf_pkg::SHORT_FRAME_BYTES;
   wire good_only = fc_q[erf_pkg::FC_GOOD_CRC];
   wire m_bad = ~fc_q[erf_pkg::FC_BAD_CRC] | ~frame.crc_ok;
   wire m_good = ~good_only | frame.crc_ok;
   wire m_scol = ~fc_q[erf_pkg::FC_SHORT_COL] | (is_short & (~good_only | frame.crc_ok));
   wire m_srej = ~fc_q[erf_pkg::FC_SHORT_REJ] | ~is_short;
   wire a_sta = fc_q[erf_pkg::FC_STATION] & is_unicast & is_station;
   wire a_for = fc_q[erf_pkg::FC_FOREIGN] & is_unicast & ~is_station;
   wire a_grp = fc_q[erf_pkg::FC_GROUP] & is_group & ~is_bcast;
   wire a_bc = fc_q[erf_pkg::FC_BCAST] & is_bcast;
   wire a_hash = fc_q[erf_pkg::FC_HASH] & frame.hash_hit;
   wire a_wake = fc_q[erf_pkg::FC_WAKEUP] & frame.wakeup_hit;
   wire any_acc = a_sta | a_for | a_grp | a_bc | a_hash | a_wake | pm_hit;
   wire accept_d = m_bad & m_good & m_scol & m_srej & any_acc;
   // frames arriving with the receiver off get no decision
   wire take = frame_valid & ctl_q[erf_pkg::CT_RX_EN];

   // ------------------------------------------------------------
   // watermarks
   // ------------------------------------------------------------
   wire [7:0] full_mark = wm_q[erf_pkg::WM_FULL_LSB +: 8];
   wire [7:0] empty_mark = wm_q[erf_pkg::WM_EMPTY_LSB +: 8];
   logic [7:0] cnt_sync1_q, cnt_q;
   logic full_prev_q, empty_prev_q;
   // marks reached by level of the synchronised count; full above empty keeps them apart
   wire full_hit = cnt_q >= full_mark;
   wire empty_hit = cnt_q <= empty_mark;
   wire auto_fc = ctl_q[erf_pkg::CT_AUTO_FC];
   logic fc_on_d;
   always_comb begin
      fc_on_d = fc_on_q;
      if (!auto_fc)
         fc_on_d = 1'b0;
      else if (full_hit)
         fc_on_d = 1'b1;
      else if (empty_hit)
         fc_on_d = 1'b0;
   end
   wire full_rise = full_hit & ~full_prev_q;
   wire empty_rise = empty_hit & ~empty_prev_q;

   // ------------------------------------------------------------
   // clocked state
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fc_q <= erf_pkg::RESET_WORD;
         wm_q <= erf_pkg::RESET_WORD;
         ctl_q <= 2'h0;
         station_q <= 48'h0;
         csum_q <= 16'h0;
         rdata_q <= erf_pkg::RESET_WORD;
      end else begin
         if (fc_wr_ok)
            fc_q <= reg_wdata & erf_pkg::FC_WRITE_MASK;
         if (reg_wr & sel_wm)
            wm_q <= reg_wdata & erf_pkg::WM_WRITE_MASK;
         if (reg_wr & sel_ct)
            ctl_q <= reg_wdata[1:0];
         if (reg_wr & sel_lo)
            station_q[31:0] <= reg_wdata;
         if (reg_wr & sel_hi)
            station_q[47:32] <= reg_wdata[15:0];
         if (reg_wr & sel_cs)
            csum_q <= reg_wdata[15:0];
         rdata_q <= reg_rd ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dec_valid_q <= 1'b0;
         accept_q <= 1'b0;
         last_acc_q <= 1'b0;
         last_valid_q <= 1'b0;
      end else begin
         dec_valid_q <= take;
         accept_q <= take & accept_d;
         if (take) begin
            last_acc_q <= accept_d;
            last_valid_q <= 1'b1;
         end
      end
   end

   // count comes from the buffer manager's domain, so it is resynchronised first
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_sync1_q <= 8'h0;
         cnt_q <= 8'h0;
         full_prev_q <= 1'b0;
         empty_prev_q <= 1'b1;
         full_evt_q <= 1'b0;
         empty_evt_q <= 1'b0;
         fc_on_q <= 1'b0;
      end else begin
         cnt_sync1_q <= rx_buffer_count;
         cnt_q <= cnt_sync1_q;
         full_prev_q <= full_hit;
         empty_prev_q <= empty_hit;
         // set wins over a software clear in the same cycle
         full_evt_q <= full_rise | (full_evt_q & ~(st_clr & reg_wdata[erf_pkg::ST_FULL_EVT]));
         empty_evt_q <= empty_rise | (empty_evt_q & ~(st_clr & reg_wdata[erf_pkg::ST_EMPTY_EVT]));
         fc_on_q <= fc_on_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign decision_valid = dec_valid_q;
   assign frame_accept = accept_q;
   assign full_level_event = full_evt_q;
   assign empty_level_event = empty_evt_q;
   assign flow_control_on = fc_on_q;
   assign receiver_enable = ctl_q[erf_pkg::CT_RX_EN];

endmodule
`default_nettype wire

// ==== verification/erf_rx_src.sv ====
// model of the mac receive path feeding frame descriptors to the filter
`timescale 1ns/1ps
`default_nettype none
module erf_rx_src (
   // clock
   input wire logic clk,
   // descriptor and buffer level toward the filter
   output logic frame_valid,
   output erf_pkg::erf_frame_s frame,
   output logic [7:0] rx_buffer_count
);
   initial begin
      frame_valid = 1'b0;
      frame = '0;
      rx_buffer_count = 8'h00;
   end
   // a released descriptor is inverted so stale fields never pass for valid ones
   task automatic send(input erf_pkg::erf_frame_s f);
      @(posedge clk);
      frame_valid <= 1'b1;
      frame <= f;
      @(posedge clk);
      frame_valid <= 1'b0;
      frame <= ~f;
   endtask
   task automatic level(input logic [7:0] c);
      @(posedge clk);
      rx_buffer_count <= c;
   endtask
endmodule
`default_nettype wire

// ==== verification/erf_rx_filter_assertions.sv ====
// concurrent checks of the receive filter and watermark block at its ports
`timescale 1ns/1ps
`default_nettype none
module erf_rx_filter_assertions (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [9:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // frame side
   input wire logic frame_valid,
   input wire erf_pkg::erf_frame_s frame,
   input wire logic [7:0] rx_buffer_count,
   // results
   input wire logic decision_valid,
   input wire logic frame_accept,
   input wire logic full_level_event,
   input wire logic empty_level_event,
   input wire logic flow_control_on,
   input wire logic receiver_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // shadow of what software programmed; config writes only land while receiving is off
   logic [15:0] cfg_q;
   logic [7:0] full_q;
   logic [7:0] empty_q;
   logic auto_q;
   wire take = frame_valid && receiver_enable;
   wire hi = rx_buffer_count >= full_q;
   wire lo = rx_buffer_count <= empty_q;
   wire marks_ok = full_q > empty_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_q <= '0;
         full_q <= '0;
         empty_q <= '0;
         auto_q <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == erf_pkg::ADDR_FILTER_CONFIG && !receiver_enable) begin
            cfg_q <= reg_wdata[15:0] & 16'hdfff;
         end
         if (reg_addr == erf_pkg::ADDR_WATERMARKS) begin
            full_q <= reg_wdata[23:16];
            empty_q <= reg_wdata[7:0];
         end
         if (reg_addr == erf_pkg::ADDR_CONTROL) begin
            auto_q <= reg_wdata[1];
         end
      end
   end
   sequence s_fill; !hi ##1 (hi && !reg_wr) [*6]; endsequence
   sequence s_drain; !lo ##1 (lo && !reg_wr) [*6]; endsequence
   property p_decide; take |=> decision_valid; endproperty
   property p_bad_crc; take && cfg_q[7] && frame.crc_ok |=> !frame_accept; endproperty
   property p_good_crc; take && cfg_q[6] && !frame.crc_ok |=> !frame_accept; endproperty
   property p_short; take && cfg_q[4] && frame.length < 16'h0040 |=> !frame_accept; endproperty
   property p_long; take && cfg_q[5] && frame.length >= 16'h0040 |=> !frame_accept; endproperty
   property p_bcast; take && cfg_q == 16'h0001 && frame.dest_addr == erf_pkg::BCAST_ADDR |=> frame_accept; endproperty
   // the count is resynchronised, so flow control follows it three cycles late
   property p_fc_on; (auto_q && marks_ok && hi && !reg_wr) [*3] |=> flow_control_on; endproperty
   property p_fc_off; (auto_q && marks_ok && lo && !reg_wr) [*3] |=> !flow_control_on; endproperty
   property p_full; s_fill |-> full_level_event; endproperty
   property p_empty; s_drain |-> empty_level_event; endproperty
   a_decide: assert property (p_decide) else $error("no decision after taken frame");
   a_bad_crc: assert property (p_bad_crc) else $error("good crc accepted");
   a_good_crc: assert property (p_good_crc) else $error("bad crc accepted");
   a_short: assert property (p_short) else $error("short frame accepted");
   a_long: assert property (p_long) else $error("long frame collected");
   a_bcast: assert property (p_bcast) else $error("broadcast refused");
   a_fc_on: assert property (p_fc_on) else $error("flow control not on");
   a_fc_off: assert property (p_fc_off) else $error("flow control not off");
   a_full: assert property (p_full) else $error("full event missing");
   a_empty: assert property (p_empty) else $error("empty event missing");
endmodule
bind erf_rx_filter erf_rx_filter_assertions u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .frame_valid(frame_valid), .frame(frame), .rx_buffer_count(rx_buffer_count),
   .decision_valid(decision_valid), .frame_accept(frame_accept), .full_level_event(full_level_event),
   .empty_level_event(empty_level_event), .flow_control_on(flow_control_on), .receiver_enable(receiver_enable));
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking testbench of the receive filter and watermark block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [9:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic [31:0] reg_rdata;
   logic frame_valid, decision_valid, frame_accept, fe, ee, fc, rx_en;
   erf_pkg::erf_frame_s frame;
   logic [7:0] cnt;
   int errors = 0;
   int check_count = 0;
   int cyc = 0;
   localparam logic [47:0] me = 48'h0002_0a0b_0c0d;
   localparam logic [47:0] oth = 48'h0004_0000_0001;
   localparam logic [47:0] grp = 48'h0100_0000_0001;
   localparam logic [47:0] bc = 48'hffff_ffff_ffff;
   erf_rx_src src (.clk(clk), .frame_valid(frame_valid), .frame(frame), .rx_buffer_count(cnt));
   erf_rx_filter DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_valid(frame_valid), .frame(frame),
      .rx_buffer_count(cnt), .decision_valid(decision_valid), .frame_accept(frame_accept),
      .full_level_event(fe), .empty_level_event(ee), .flow_control_on(fc), .receiver_enable(rx_en));
   initial forever #25 clk = ~clk;
   // a hang counts as a failure
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] e, input string n);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(n, e, reg_rdata);
   endtask
   // filter settings may only change while receiving is off
   task automatic cfg(input logic [31:0] c);
      wr(erf_pkg::ADDR_CONTROL, 32'h0);
      wr(erf_pkg::ADDR_FILTER_CONFIG, c);
      wr(erf_pkg::ADDR_CONTROL, 32'h3);
   endtask
   task automatic fr(input logic [47:0] d, input logic e, input logic [15:0] len = 16'd100,
                     input logic ok = 1'b1, input logic [15:0] cs = 16'h1234, input logic hw = 1'b0);
      src.send('{d, len, ok, cs, hw, hw});
      #1 chk("decision_valid", 32'h1, {31'h0, decision_valid});
      chk("frame_accept", {31'h0, e}, {31'h0, frame_accept});
   endtask
   task automatic lvl(input logic [7:0] c);
      src.level(c);
      repeat (6) @(posedge clk);
      #1;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(erf_pkg::ADDR_FILTER_CONFIG, 32'h0, "rx_filter_config");
      wr(erf_pkg::ADDR_FILTER_CONFIG, 32'hffff_ffff);
      rd(erf_pkg::ADDR_FILTER_CONFIG, 32'h0000_dfff, "rx_filter_config");
      wr(erf_pkg::ADDR_WATERMARKS, 32'hffff_ffff);
      rd(erf_pkg::ADDR_WATERMARKS, 32'h00ff_00ff, "rx_buffer_watermarks");
      wr(10'h3fc, 32'h1234_5678);
      rd(10'h3fc, 32'h0, "unmapped");
      wr(erf_pkg::ADDR_WATERMARKS, 32'h0010_0004);
      wr(erf_pkg::ADDR_STATION_LO, 32'h0a0b_0c0d);
      wr(erf_pkg::ADDR_STATION_HI, 32'h0000_0002);
      wr(erf_pkg::ADDR_CHECKSUM, 32'h0000_1234);
      cfg(32'h1);
      wr(erf_pkg::ADDR_FILTER_CONFIG, 32'h2);
      rd(erf_pkg::ADDR_FILTER_CONFIG, 32'h1, "rx_filter_config");
      $display("test registers done");
      fr(bc, 1'b1);
      fr(me, 1'b0);
      cfg(32'h2);
      fr(grp, 1'b1);
      cfg(32'h8);
      fr(me, 1'b1);
      fr(oth, 1'b0);
      cfg(32'h4);
      fr(oth, 1'b1);
      fr(me, 1'b0);
      cfg(32'h41);
      fr(bc, 1'b0, 16'd100, 1'b0);
      cfg(32'h81);
      fr(bc, 1'b0);
      fr(bc, 1'b1, 16'd100, 1'b0);
      cfg(32'h11);
      fr(bc, 1'b0, 16'd63);
      fr(bc, 1'b1, 16'd64);
      cfg(32'h21);
      fr(bc, 1'b0, 16'd64);
      fr(bc, 1'b1, 16'd63);
      cfg(32'h61);
      fr(bc, 1'b0, 16'd63, 1'b0);
      cfg(32'h8000);
      fr(oth, 1'b1, 16'd100, 1'b1, 16'h0, 1'b1);
      cfg(32'h4000);
      fr(oth, 1'b1, 16'd100, 1'b1, 16'h0, 1'b1);
      $display("test acceptance done");
      for (int s = 0; s < 10; s++) begin
         cfg(32'(s) << 8);
         fr((s == 6 || s == 7) ? bc : me, s != 0, 16'd100, 1'b1, 16'h1234, 1'b1);
         fr((s >= 2 && s <= 5) ? grp : me, s == 1);
         cfg((32'(s) << 8) | 32'h1000);
         fr((s == 6 || s == 7) ? bc : me, 1'b0, 16'd100, 1'b1, 16'h1234, 1'b1);
         fr((s == 6 || s == 7) ? bc : me, s != 0, 16'd100, 1'b1, 16'h4321, 1'b1);
      end
      $display("test pattern match done");
      wr(erf_pkg::ADDR_STATUS, 32'h3);
      lvl(8'h08);
      lvl(8'h10);
      chk("full_level_event", 32'h1, {31'h0, fe});
      chk("flow_control_on", 32'h1, {31'h0, fc});
      lvl(8'h04);
      chk("empty_level_event", 32'h1, {31'h0, ee});
      chk("flow_control_on", 32'h0, {31'h0, fc});
      rd(erf_pkg::ADDR_STATUS, 32'h0000_001b, "status");
      wr(erf_pkg::ADDR_STATUS, 32'h1);
      #1 chk("full_level_event", 32'h0, {31'h0, fe});
      wr(erf_pkg::ADDR_CONTROL, 32'h1);
      lvl(8'h10);
      chk("flow_control_on", 32'h0, {31'h0, fc});
      $display("test watermarks done");
      results();
   end
endmodule
`default_nettype wire
